//--- design/mac_ctrl_defs.svh
// Offsets, field positions, reset values and timing counts of the MAC control block
`ifndef MAC_CTRL_DEFS_SVH
`define MAC_CTRL_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define REG_IDX_W 6
`define REG_IDX_CONTROL 6'h01
`define REG_IDX_ADDR_UPPER 6'h02
`define REG_IDX_STATUS 6'h08

// Control register fields
`define CTRL_RX_ENABLE_BIT 2
`define CTRL_TX_ENABLE_BIT 3
`define CTRL_DEFER_CHECK_BIT 5
`define CTRL_RST 32'h00000000
`define CTRL_WR_MASK 32'h0000002c

// Upper station address register
`define ADDR_UPPER_RST 32'h0000fff
`define ADDR_UPPER_FIELD_W 16

// Status register fields
`define STAT_INIT_BUSY_BIT 0
`define STAT_DEFER_ABORT_BIT 1
`define STAT_DEFERRING_BIT 2
`define STAT_TX_FIFO_FULL_BIT 3
`define STAT_UPPER_MATCH_BIT 4

// EEPROM byte locations of the upper address
`define EE_ADDR_UPPER_LO 8'h05
`define EE_ADDR_UPPER_HI 8'h06

// Received destination byte positions, counted from zero
`define RX_POS_UPPER_LO 3'h4
`define RX_POS_UPPER_HI 3'h5

// Deferral limit in bit times and line-rate timing
`define DEFER_LIMIT_BITS 24288
`define DEFER_CNT_W 20
`define CLK_RATE_MBPS 100
`define LINE_RATE_SLOW_MBPS 10
`define LINE_RATE_FAST_MBPS 100
`define CYC_PER_BIT_SLOW (`CLK_RATE_MBPS / `LINE_RATE_SLOW_MBPS)
`define CYC_PER_BIT_FAST (`CLK_RATE_MBPS / `LINE_RATE_FAST_MBPS)
`define BIT_DIV_W 4

// Transmit buffer
`define TX_FIFO_DEPTH 8

`endif

//--- design/mac_ctrl_pkg.sv
// Types shared by the MAC control block
package mac_ctrl_pkg;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } beat_s;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_DEFER,
      TX_SEND,
      TX_BACKOFF,
      TX_DROP
   } tx_state_e;

endpackage : mac_ctrl_pkg

//--- design/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wrPtr_ff, nxt_wrPtr;
   logic [AW-1:0] rdPtr_ff, nxt_rdPtr;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push;
   logic pop;

   assign inReady = (cnt_ff != FULL_CNT);
   assign outValid = (cnt_ff != '0);
   assign outData = mem_ff[rdPtr_ff];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always_comb begin
      nxt_wrPtr = wrPtr_ff;
      nxt_rdPtr = rdPtr_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_wrPtr = (wrPtr_ff == LAST_PTR) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rdPtr = (rdPtr_ff == LAST_PTR) ? '0 : rdPtr_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage needs no reset; only slots behind the count are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wrPtr_ff] <= inData;
      end
   end
endmodule : sync_fifo
`default_nettype wire

//--- design/bit_time_tick.sv
// One-cycle enable per bit time at the negotiated line rate
`timescale 1ns/100ps
`default_nettype none
`include "mac_ctrl_defs.svh"
module bit_time_tick (
   input wire logic clk,
   input wire logic srst,
   input wire logic speedFast,
   output logic bitTick
);
   localparam logic [`BIT_DIV_W-1:0] SLOW_LAST = `BIT_DIV_W'(`CYC_PER_BIT_SLOW - 1);
   localparam logic [`BIT_DIV_W-1:0] FAST_LAST = `BIT_DIV_W'(`CYC_PER_BIT_FAST - 1);

   logic [`BIT_DIV_W-1:0] div_ff, nxt_div;
   logic [`BIT_DIV_W-1:0] lastVal;

   assign lastVal = speedFast ? FAST_LAST : SLOW_LAST;
   assign bitTick = (div_ff >= lastVal);

   always_comb begin
      nxt_div = bitTick ? '0 : div_ff + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end
endmodule : bit_time_tick
`default_nettype wire

//--- design/mac_txrx_ctrl.sv
// MAC transmit/receive enables, deferral limit and upper station address with Avalon-MM registers
//
// Notes on behaviour
// R1: With deferral check set, abort the attempt after deferring over 24288 bit times.
// R2: Deferral counting starts only when a frame is ready but carrier blocks it.
// R3: Each new deferral restarts the timer from zero; time never accumulates.
// R4: With deferral check clear, wait for a free medium without limit.
// R5: Transmit enable set sends buffered frames; cleared, no frame starts.
// R6: Receive enable set accepts PHY frames; cleared, no frames are accepted.
// R7: Upper address register holds address bits 47..32 in 15..0; 31..16 reserved.
// R8: At power-on a programmed EEPROM loads the upper address field.
// R9: EEPROM location 0x05 loads the low byte, 0x06 the high byte.
// R10: Field undefined until the load; host writes accepted after initialization.
// R11: Received byte five matches the low byte, byte six the high byte.
// R12: Deferral counter advances once per bit time at 10 or 100 Mb/s.
`timescale 1ns/100ps
`default_nettype none
`include "mac_ctrl_defs.svh"
module mac_txrx_ctrl #(
   parameter logic [`DEFER_CNT_W-1:0] DEFER_LIMIT = `DEFER_CNT_W'(`DEFER_LIMIT_BITS)
) (
   input wire logic clk,
   input wire logic srst,
   // Avalon-MM slave, byte addressed
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // EEPROM controller load stream
   input wire logic eeLoadActive,
   input wire logic eeByteValid,
   input wire logic [7:0] eeByteAddr,
   input wire logic [7:0] eeByteData,
   // PHY status
   input wire logic speedFast,
   input wire logic carrierSense,
   input wire logic backoffActive,
   // Host-side transmit stream into the buffer
   input wire logic txInValid,
   output logic txInReady,
   input wire mac_ctrl_pkg::beat_s txIn,
   // Transmit stream toward the PHY
   output logic txOutValid,
   input wire logic txOutReady,
   output mac_ctrl_pkg::beat_s txOut,
   output logic txAbort,
   // Receive stream from the PHY
   input wire logic rxInValid,
   input wire mac_ctrl_pkg::beat_s rxIn,
   // Receive stream toward the host buffer
   output logic rxOutValid,
   output mac_ctrl_pkg::beat_s rxOut,
   output logic rxUpperMatch
);
   // Register bus
   logic ack_ff, nxt_ack;
   logic [31:0] rdData_ff, nxt_rdData;
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [`ADDR_UPPER_FIELD_W-1:0] addrUpper_ff, nxt_addrUpper;
   logic abortSticky_ff, nxt_abortSticky;
   logic [`REG_IDX_W-1:0] regIdx;
   logic [31:0] laneMask;
   logic [31:0] readMux;
   logic [31:0] addrUpperWord;
   logic [31:0] statusWord;
   logic busReq;
   logic wrStrobe;
   logic initBusy;
   logic txEnable;
   logic rxEnable;
   logic deferCheck;

   // Transmit path
   mac_ctrl_pkg::tx_state_e txState_ff, nxt_txState;
   logic [`DEFER_CNT_W-1:0] deferCnt_ff, nxt_deferCnt;
   logic bitTick;
   logic fifoValid;
   logic fifoReady;
   logic fifoFull;
   mac_ctrl_pkg::beat_s fifoBeat;

   // Receive path
   logic rxInFrame_ff, nxt_rxInFrame;
   logic rxPass_ff, nxt_rxPass;
   logic [2:0] rxPos_ff, nxt_rxPos;
   logic loMatch_ff, nxt_loMatch;
   logic rxMatch_ff, nxt_rxMatch;
   logic rxOutValid_ff, nxt_rxOutValid;
   mac_ctrl_pkg::beat_s rxOut_ff, nxt_rxOut;
   logic rxPassNow;

   assign regIdx = avs_address[7:2];
   assign initBusy = eeLoadActive;
   assign txEnable = ctrl_ff[`CTRL_TX_ENABLE_BIT];
   assign rxEnable = ctrl_ff[`CTRL_RX_ENABLE_BIT];
   assign deferCheck = ctrl_ff[`CTRL_DEFER_CHECK_BIT];
   assign laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign addrUpperWord = {16'h0000, addrUpper_ff}; // R7
   assign statusWord = {27'h0000000, rxMatch_ff, fifoFull,
                        (txState_ff == mac_ctrl_pkg::TX_DEFER), abortSticky_ff, initBusy};

   // One wait state per access; held off entirely while the EEPROM load runs
   assign busReq = (avs_read | avs_write) & ~initBusy; // R10
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata = rdData_ff;
   assign wrStrobe = avs_write & ack_ff;

   always_comb begin
      case (regIdx)
         `REG_IDX_CONTROL: readMux = ctrl_ff;
         `REG_IDX_ADDR_UPPER: readMux = addrUpperWord;
         `REG_IDX_STATUS: readMux = statusWord;
         default: readMux = 32'h00000000;
      endcase
   end

   always_comb begin
      nxt_ack = busReq & ~ack_ff;
      nxt_rdData = rdData_ff;
      if (busReq && !ack_ff && avs_read) begin
         nxt_rdData = readMux;
      end
      nxt_ctrl = ctrl_ff;
      nxt_addrUpper = addrUpper_ff;
      nxt_abortSticky = abortSticky_ff;
      if (wrStrobe && regIdx == `REG_IDX_CONTROL) begin
         nxt_ctrl = ((ctrl_ff & ~laneMask) | (avs_writedata & laneMask)) & `CTRL_WR_MASK;
      end
      if (wrStrobe && regIdx == `REG_IDX_ADDR_UPPER) begin
         nxt_addrUpper = (addrUpper_ff & ~laneMask[15:0]) | (avs_writedata[15:0] & laneMask[15:0]); // R10
      end
      if (wrStrobe && regIdx == `REG_IDX_STATUS && avs_byteenable[0]
          && avs_writedata[`STAT_DEFER_ABORT_BIT]) begin
         nxt_abortSticky = 1'b0;
      end
      // A new abort in the clearing cycle wins
      if (txAbort) begin
         nxt_abortSticky = 1'b1;
      end
      if (eeByteValid && eeByteAddr == `EE_ADDR_UPPER_LO) begin
         nxt_addrUpper[7:0] = eeByteData; // R8 R9
      end
      if (eeByteValid && eeByteAddr == `EE_ADDR_UPPER_HI) begin
         nxt_addrUpper[15:8] = eeByteData; // R8 R9
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ack_ff <= 1'b0;
         rdData_ff <= 32'h00000000;
         ctrl_ff <= `CTRL_RST;
         addrUpper_ff <= `ADDR_UPPER_FIELD_W'(`ADDR_UPPER_RST);
         abortSticky_ff <= 1'b0;
      end else begin
         ack_ff <= nxt_ack;
         rdData_ff <= nxt_rdData;
         ctrl_ff <= nxt_ctrl;
         addrUpper_ff <= nxt_addrUpper;
         abortSticky_ff <= nxt_abortSticky;
      end
   end

   sync_fifo #(
      .WIDTH($bits(mac_ctrl_pkg::beat_s)),
      .DEPTH(`TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(clk),
      .srst(srst),
      .inValid(txInValid),
      .inReady(txInReady),
      .inData(txIn),
      .outValid(fifoValid),
      .outReady(fifoReady),
      .outData(fifoBeat)
   );

   assign fifoFull = ~txInReady;

   bit_time_tick u_bit_tick (
      .clk(clk),
      .srst(srst),
      .speedFast(speedFast),
      .bitTick(bitTick)
   ); // R12

   assign txOut = fifoBeat;
   assign txOutValid = (txState_ff == mac_ctrl_pkg::TX_SEND) & fifoValid;
   assign fifoReady = ((txState_ff == mac_ctrl_pkg::TX_SEND) & txOutReady)
                      | (txState_ff == mac_ctrl_pkg::TX_DROP);

   always_comb begin
      nxt_txState = txState_ff;
      nxt_deferCnt = deferCnt_ff;
      txAbort = 1'b0;
      case (txState_ff)
         mac_ctrl_pkg::TX_IDLE: begin
            nxt_deferCnt = '0; // R3
            if (txEnable && fifoValid) begin // R5
               nxt_txState = carrierSense ? mac_ctrl_pkg::TX_DEFER : mac_ctrl_pkg::TX_SEND; // R2
            end
         end
         mac_ctrl_pkg::TX_DEFER: begin
            if (bitTick) begin
               nxt_deferCnt = deferCnt_ff + 1'b1; // R12
            end
            if (!txEnable) begin
               nxt_txState = mac_ctrl_pkg::TX_IDLE; // R5
            end else if (!carrierSense) begin
               nxt_txState = mac_ctrl_pkg::TX_SEND;
            end else if (deferCheck && deferCnt_ff > DEFER_LIMIT) begin // R1 R4
               txAbort = 1'b1; // R1
               nxt_txState = mac_ctrl_pkg::TX_DROP;
            end
         end
         mac_ctrl_pkg::TX_SEND: begin
            // A frame once started is finished even if transmit is disabled meanwhile
            if (backoffActive) begin
               nxt_txState = mac_ctrl_pkg::TX_BACKOFF;
            end else if (fifoValid && txOutReady && fifoBeat.last) begin
               nxt_txState = mac_ctrl_pkg::TX_IDLE;
            end
         end
         mac_ctrl_pkg::TX_BACKOFF: begin
            // Passing through idle restarts any later deferral from zero
            if (!backoffActive) begin
               nxt_txState = mac_ctrl_pkg::TX_IDLE; // R3
            end
         end
         mac_ctrl_pkg::TX_DROP: begin
            if (fifoValid && fifoBeat.last) begin
               nxt_txState = mac_ctrl_pkg::TX_IDLE;
            end
         end
         default: begin
            nxt_txState = mac_ctrl_pkg::TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         txState_ff <= mac_ctrl_pkg::TX_IDLE;
         deferCnt_ff <= '0;
      end else begin
         txState_ff <= nxt_txState;
         deferCnt_ff <= nxt_deferCnt;
      end
   end

   // Enable is sampled at a frame's first byte so frames are never cut short
   assign rxPassNow = rxInFrame_ff ? rxPass_ff : rxEnable; // R6

   always_comb begin
      nxt_rxInFrame = rxInFrame_ff;
      nxt_rxPass = rxPass_ff;
      nxt_rxPos = rxPos_ff;
      nxt_loMatch = loMatch_ff;
      nxt_rxMatch = rxMatch_ff;
      nxt_rxOutValid = 1'b0;
      nxt_rxOut = rxOut_ff;
      if (rxInValid) begin
         nxt_rxPass = rxPassNow;
         nxt_rxInFrame = ~rxIn.last;
         nxt_rxOutValid = rxPassNow; // R6
         if (rxPassNow) begin
            nxt_rxOut = rxIn;
         end
         if (!rxInFrame_ff) begin
            nxt_rxPos = 3'h1;
            nxt_rxMatch = 1'b0;
         end else if (rxPos_ff != 3'h7) begin
            nxt_rxPos = rxPos_ff + 1'b1;
         end
         if (rxInFrame_ff && rxPos_ff == `RX_POS_UPPER_LO) begin
            nxt_loMatch = (rxIn.data == addrUpper_ff[7:0]); // R11
         end
         if (rxInFrame_ff && rxPos_ff == `RX_POS_UPPER_HI) begin
            nxt_rxMatch = loMatch_ff & (rxIn.data == addrUpper_ff[15:8]); // R11
         end
         if (rxIn.last) begin
            nxt_rxPos = 3'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rxInFrame_ff <= 1'b0;
         rxPass_ff <= 1'b0;
         rxPos_ff <= 3'h0;
         loMatch_ff <= 1'b0;
         rxMatch_ff <= 1'b0;
         rxOutValid_ff <= 1'b0;
         rxOut_ff <= '0;
      end else begin
         rxInFrame_ff <= nxt_rxInFrame;
         rxPass_ff <= nxt_rxPass;
         rxPos_ff <= nxt_rxPos;
         loMatch_ff <= nxt_loMatch;
         rxMatch_ff <= nxt_rxMatch;
         rxOutValid_ff <= nxt_rxOutValid;
         rxOut_ff <= nxt_rxOut;
      end
   end

   assign rxOutValid = rxOutValid_ff;
   assign rxOut = rxOut_ff;
   assign rxUpperMatch = rxMatch_ff;
endmodule : mac_txrx_ctrl
`default_nettype wire

//--- verification/mac_txrx_ctrl_checker.sv
// Port-level assertions for the MAC control block
`timescale 1ns/100ps
`default_nettype none
`include "mac_ctrl_defs.svh"
module mac_txrx_ctrl_checker #(
   parameter logic [`DEFER_CNT_W-1:0] DEFER_LIMIT = `DEFER_CNT_W'(`DEFER_LIMIT_BITS)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic eeLoadActive,
   input wire logic carrierSense,
   input wire logic txOutValid,
   input wire logic txOutReady,
   input wire mac_ctrl_pkg::beat_s txOut,
   input wire logic txAbort,
   input wire logic rxInValid,
   input wire mac_ctrl_pkg::beat_s rxIn,
   input wire logic rxOutValid,
   input wire mac_ctrl_pkg::beat_s rxOut
);
   logic transmit_enable_bit_ff, receive_enable_bit_ff, chk_ff, rxOpen_ff, txOpen_ff;
   logic [15:0] csRun_ff;
   wire logic ctlWr = avs_write && !avs_waitrequest && avs_address[7:2] == `REG_IDX_CONTROL && avs_byteenable[0];

   // Shadow of the control bits, updated at the same answer edge as the register
   always_ff @(posedge clk) begin
      if (srst) begin
         {chk_ff, transmit_enable_bit_ff, receive_enable_bit_ff, rxOpen_ff, txOpen_ff} <= 5'h00;
         csRun_ff <= 16'h0000;
      end else begin
         if (ctlWr) begin
            {chk_ff, transmit_enable_bit_ff, receive_enable_bit_ff} <= {avs_writedata[5], avs_writedata[3], avs_writedata[2]};
         end
         if (rxInValid) begin
            rxOpen_ff <= !rxIn.last;
         end
         if (txOutValid) begin
            txOpen_ff <= !(txOutReady && txOut.last);
         end
         csRun_ff <= carrierSense ? csRun_ff + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence rxFirst;
      rxInValid && !rxOpen_ff;
   endsequence
   sequence busStall;
      (avs_read || avs_write) && !eeLoadActive && avs_waitrequest;
   endsequence

   bus_answer_a: assert property (busStall |=> !avs_waitrequest) else $error("bus request not answered");
   load_stall_a: assert property (eeLoadActive && (avs_read || avs_write) |-> avs_waitrequest)
      else $error("bus answered during load");
   upper_rsvd_a: assert property (avs_read && !avs_waitrequest && avs_address[7:2] == `REG_IDX_ADDR_UPPER
      |-> avs_readdata[31:16] == 16'h0000) else $error("reserved address bits not zero");
   rx_pass_a: assert property (rxFirst ##0 receive_enable_bit_ff |=> rxOutValid && rxOut == $past(rxIn))
      else $error("enabled receive beat not passed");
   rx_block_a: assert property (rxFirst ##0 !receive_enable_bit_ff |=> !rxOutValid) else $error("disabled receive passed");
   rx_source_a: assert property (rxOutValid |-> $past(rxInValid)) else $error("receive beat from nowhere");
   abort_gate_a: assert property (txAbort |-> chk_ff && carrierSense) else $error("abort without check");
   abort_late_a: assert property (txAbort |-> csRun_ff >= 16'(DEFER_LIMIT)) else $error("abort too early");
   abort_pulse_a: assert property (txAbort |=> !txAbort) else $error("abort longer than a cycle");
   tx_off_a: assert property (!transmit_enable_bit_ff && !$past(transmit_enable_bit_ff) && !txOpen_ff |-> !txOutValid)
      else $error("frame started while disabled");
endmodule : mac_txrx_ctrl_checker
`default_nettype wire

//--- verification/phy_partner.sv
// Behavioural PHY: carrier, paced transmit acceptance, receive frames
`timescale 1ns/100ps
`default_nettype none
module phy_partner (
   input wire logic clk,
   input wire logic stall,
   input wire logic csReq,
   output logic carrierSense,
   input wire logic txOutValid,
   input wire mac_ctrl_pkg::beat_s txOut,
   output logic txOutReady,
   output logic rxInValid,
   output mac_ctrl_pkg::beat_s rxIn
);
   logic [7:0] seen[$];
   mac_ctrl_pkg::beat_s rxQ[$];
   logic ph = 1'b0;
   // Own receive activity shows as carrier, as on a half-duplex line
   assign carrierSense = csReq || rxInValid;
   initial begin
      txOutReady = 1'b0;
      rxInValid = 1'b0;
      rxIn = '0;
   end
   always @(posedge clk) begin
      ph <= !ph;
      txOutReady <= !stall || ph;
      if (txOutValid && txOutReady) begin
         seen.push_back(txOut.data);
      end
      rxInValid <= rxQ.size() != 0;
      // Idle data keeps toggling so a stale beat never looks valid
      rxIn <= rxQ.size() != 0 ? rxQ.pop_front() : ~rxIn;
   end
   task automatic sendRx(input logic [15:0] u);
      for (int i = 0; i < 6; i++) begin
         rxQ.push_back('{data: i < 4 ? 8'h11 : u[8*(i-4) +: 8], last: i == 5});
      end
      while (rxQ.size() != 0) @(posedge clk);
   endtask : sendRx
endmodule : phy_partner
`default_nettype wire

//--- verification/mac_txrx_ctrl_tb_top.sv
// Testbench for the MAC control block
`timescale 1ns/100ps
`default_nettype none
module mac_txrx_ctrl_tb_top;
   localparam int LIMN = 20;
   logic clk, srst, avs_read, avs_write, avs_waitrequest, eeLoadActive, eeByteValid, speedFast, carrierSense;
   logic backoffActive, txInValid, txInReady, txOutValid, txOutReady, txAbort, rxInValid, rxOutValid;
   logic rxUpperMatch, stall, csReq;
   logic [7:0] avs_address, eeByteAddr, eeByteData, a;
   logic [31:0] avs_writedata, avs_readdata, q, d, e;
   logic [3:0] avs_byteenable, be;
   mac_ctrl_pkg::beat_s txIn, txOut, rxIn, rxOut;
   int errTotal = 0, checksDone = 0, cyc = 0, aborts = 0, rxCnt = 0, n, t0, dv;
   logic [75:0] rows [5] = '{
      {8'h08, 32'hffff1234, 4'hf, 32'h00001234},
      {8'h08, 32'h0000ab00, 4'h2, 32'h0000ab34},
      {8'h04, 32'hffffffff, 4'hf, 32'h0000002c},
      {8'h04, 32'h00000000, 4'hf, 32'h00000000},
      {8'h3c, 32'hffffffff, 4'hf, 32'h00000000}};

   mac_txrx_ctrl #(.DEFER_LIMIT(20'(LIMN))) DUT (.clk, .srst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .eeLoadActive, .eeByteValid,
      .eeByteAddr, .eeByteData, .speedFast, .carrierSense, .backoffActive, .txInValid, .txInReady, .txIn,
      .txOutValid, .txOutReady, .txOut, .txAbort, .rxInValid, .rxIn, .rxOutValid, .rxOut, .rxUpperMatch);
   phy_partner phy (.clk, .stall, .csReq, .carrierSense, .txOutValid, .txOut, .txOutReady, .rxInValid, .rxIn);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (txAbort === 1'b1) aborts <= aborts + 1;
      if (rxOutValid === 1'b1) rxCnt <= rxCnt + 1;
      if (cyc == 20000) begin
         errTotal++;
         testDone();
      end
   end

   task automatic testDone();
      if (errTotal == 0 && checksDone > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : testDone
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errTotal++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Starts one edge late so a release and a new request never share a time step
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] bl);
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= ad;
      avs_writedata <= wd;
      avs_byteenable <= bl;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic push(input int cnt, input logic [7:0] b);
      for (int i = 0; i < cnt; i++) begin
         txInValid <= 1'b1;
         txIn <= '{data: b + 8'(i), last: i == cnt - 1};
         do @(posedge clk); while (txInReady !== 1'b1);
      end
      txInValid <= 1'b0;
   endtask : push
   task automatic eeByte(input logic [7:0] ad, input logic [7:0] b);
      @(posedge clk);
      eeByteValid <= 1'b1;
      eeByteAddr <= ad;
      eeByteData <= b;
      @(posedge clk);
      eeByteValid <= 1'b0;
   endtask : eeByte
   task automatic waitSeen(input int cnt);
      repeat (400) if (phy.seen.size() < cnt) @(posedge clk);
   endtask : waitSeen
   // Deferral, send one beat, back-off, deferral again, send the rest
   task automatic sendHeld(input logic [31:0] c, input int hold);
      int m;
      m = phy.seen.size();
      bus(1'b1, 8'h04, c, 4'hf);
      csReq <= 1'b1;
      // Three beats keep a tail in the buffer past the back-off, whichever edge it lands on
      push(3, 8'h60);
      repeat (hold) @(posedge clk);
      csReq <= 1'b0;
      waitSeen(m + 1);
      backoffActive <= 1'b1;
      csReq <= 1'b1;
      repeat (4) @(posedge clk);
      backoffActive <= 1'b0;
      repeat (hold) @(posedge clk);
      csReq <= 1'b0;
      waitSeen(m + 3);
   endtask : sendHeld

   initial begin
      srst = 1'b1;
      {avs_read, avs_write, eeLoadActive, eeByteValid, backoffActive, txInValid, stall, csReq} = 8'h00;
      {avs_address, eeByteAddr, eeByteData, avs_writedata, avs_byteenable} = 60'h0;
      speedFast = 1'b1;
      txIn = '0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         {a, d, be, e} = rows[i];
         bus(1'b1, a, d, be);
         bus(1'b0, a, 32'h0, 4'hf);
         chk(q, e);
      end
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      bus(1'b0, 8'h08, 32'h0, 4'hf);
      chk(q, 32'h00000fff);
      bus(1'b0, 8'h04, 32'h0, 4'hf);
      chk(q, 32'h00000000);
      eeLoadActive <= 1'b1;
      fork
         bus(1'b0, 8'h08, 32'h0, 4'hf);
         begin
            eeByte(8'h06, 8'hc3);
            eeByte(8'h01, 8'h77);
            eeByte(8'h05, 8'h5a);
            eeLoadActive <= 1'b0;
         end
      join
      chk(q, 32'h0000c35a);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, 8'h04, k != 0 ? 32'h4 : 32'h0, 4'hf);
         n = rxCnt;
         phy.sendRx(k == 2 ? 16'h5ac3 : 16'hc35a);
         repeat (3) @(posedge clk);
         chk(rxCnt - n, k != 0 ? 6 : 0);
         if (k != 0) chk(rxUpperMatch, k == 1);
      end
      stall <= 1'b1;
      push(8, 8'h10);
      @(posedge clk);
      chk(txInReady, 0);
      repeat (10) @(posedge clk);
      chk(phy.seen.size(), 0);
      bus(1'b0, 8'h20, 32'h0, 4'hf);
      chk(q, 32'h00000008);
      bus(1'b1, 8'h04, 32'h0000000c, 4'hf);
      waitSeen(8);
      for (int i = 0; i < 8; i++) chk(phy.seen[i], 8'h10 + 8'(i));
      phy.seen.delete();
      for (int s = 0; s < 2; s++) begin
         speedFast <= s == 1;
         dv = s == 1 ? 1 : 10;
         bus(1'b1, 8'h04, 32'h0000002c, 4'hf);
         csReq <= 1'b1;
         push(2, 8'h40);
         t0 = cyc;
         while (txAbort !== 1'b1 && cyc - t0 < 400) @(posedge clk);
         chk(cyc - t0 >= LIMN * dv && cyc - t0 <= (LIMN + 2) * dv + 4, 1);
         csReq <= 1'b0;
         repeat (20) @(posedge clk);
         chk(phy.seen.size(), 0);
         bus(1'b0, 8'h20, 32'h0, 4'hf);
         chk(q[1], 1);
         bus(1'b1, 8'h20, 32'h2, 4'hf);
      end
      chk(aborts, 2);
      sendHeld(32'h0000002c, 15);
      sendHeld(32'h0000000c, 60);
      chk(aborts, 2);
      chk(phy.seen.size(), 6);
      testDone();
   end
endmodule : mac_txrx_ctrl_tb_top
bind mac_txrx_ctrl mac_txrx_ctrl_checker #(.DEFER_LIMIT(DEFER_LIMIT)) portChecker (.clk, .srst, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .eeLoadActive,
   .carrierSense, .txOutValid, .txOutReady, .txOut, .txAbort, .rxInValid, .rxIn, .rxOutValid, .rxOut);
`default_nettype wire
